// File: src/gyro_readout_port.sv
// device end: serial configuration and conversion readout port of the gyro
//
// Behaviour
// - results leave only inside a read frame
// - configuration bits enter only inside config frame
// - config frame end loads last eight bits
// - results are offset binary, zero gives 8192
// - conversion starts at read frame fall
// - msb appears at sixth falling clock edge
// - a readout cycle spans twenty clock cycles
// - read frame rise starts acquiring the input
// - code 00100000 selects rate, self-test off
// - db4 temperature, none aux two, db6 aux one
// - code 00100010 gives positive self-test on rate
// - code 00100001 gives negative self-test on rate
// - host allows over 40 us for temperature
// - host result register holds the previous and latest readings side by side
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
module gyro_readout_port (
  gyro_link_if.device link,
  input wire logic reset_n,
  input wire logic [gyro_link_pkg::RES_W-1:0] rate_sample,
  input wire logic [gyro_link_pkg::RES_W-1:0] temp_sample,
  input wire logic [gyro_link_pkg::RES_W-1:0] aux_one_sample,
  input wire logic [gyro_link_pkg::RES_W-1:0] aux_two_sample,
  output gyro_link_pkg::source_t source,
  output logic selftest_pos,
  output logic selftest_neg,
  output logic acquiring,
  output logic converting,
  output logic [gyro_link_pkg::CTRL_W-1:0] control,
  output logic short_read_frame,
  output logic short_config_frame
);
  localparam int CW = gyro_link_pkg::CNT_W;
  localparam logic [3:0] CFG_FULL = 4'(gyro_link_pkg::CTRL_W);

  // edge counter must reach the frame end and the bit counter the register width
  if (gyro_link_pkg::LAST_OUT_EDGE >= gyro_link_pkg::FRAME_EDGES
    || gyro_link_pkg::FRAME_EDGES >= (1 << CW)
    || gyro_link_pkg::CTRL_W >= 16) begin
    $error("gyro_readout_port: link constants out of range");
  end

  // decodes the control register into the selected source
  function automatic gyro_link_pkg::source_t decode_source(
    input logic [gyro_link_pkg::CTRL_W-1:0] c);
    gyro_link_pkg::source_t s;
    s = gyro_link_pkg::SRC_AUX_TWO;
    if (c[gyro_link_pkg::BIT_RATE]) begin
      s = gyro_link_pkg::SRC_RATE;
    end else if (c[gyro_link_pkg::BIT_TEMP]) begin
      s = gyro_link_pkg::SRC_TEMP;
    end else if (c[gyro_link_pkg::BIT_AUX_ONE]) begin
      s = gyro_link_pkg::SRC_AUX_ONE;
    end
    return s;
  endfunction

  // two's complement sample to offset binary
  function automatic logic [gyro_link_pkg::RES_W-1:0] to_offset(
    input logic [gyro_link_pkg::RES_W-1:0] v);
    return v ^ gyro_link_pkg::MID_SCALE;
  endfunction

  logic [gyro_link_pkg::CTRL_W-1:0] shift_in;
  logic [gyro_link_pkg::CTRL_W-1:0] next_shift_in;
  logic [3:0] cfg_bits;
  logic [3:0] next_cfg_bits;
  logic [gyro_link_pkg::CTRL_W-1:0] next_control;
  logic next_short_config;
  logic [gyro_link_pkg::RES_W-1:0] held;
  logic [gyro_link_pkg::RES_W-1:0] next_held;
  logic [CW-1:0] edge_cnt;
  logic [CW-1:0] next_edge_cnt;
  logic [gyro_link_pkg::RES_W-1:0] out_shift;
  logic [gyro_link_pkg::RES_W-1:0] next_out_shift;
  logic dout_q;
  logic next_dout_q;
  logic [CW-1:0] last_cnt;
  logic [CW-1:0] next_last_cnt;
  logic frame_clr_n;
  logic cfg_clr_n;
  gyro_link_pkg::source_t sel;

  assign sel = decode_source(control);
  assign source = sel;
  assign selftest_pos = control[gyro_link_pkg::BIT_ST_POS];
  assign selftest_neg = control[gyro_link_pkg::BIT_ST_NEG];
  assign acquiring = link.read_frame_select_n;
  assign converting = ~link.read_frame_select_n
    & (edge_cnt < CW'(gyro_link_pkg::FRAME_EDGES));
  assign link.dout = dout_q;
  assign short_read_frame = last_cnt != CW'(gyro_link_pkg::FRAME_EDGES);
  // the frame line itself clears the edge counter between frames
  assign frame_clr_n = reset_n & ~link.read_frame_select_n;
  // the config frame line clears the bit counter between config frames
  assign cfg_clr_n = reset_n & ~link.config_frame_select_n;

  // configuration shift register, sampled on rising clock inside the frame
  always_comb begin
    next_shift_in = shift_in;
    next_cfg_bits = cfg_bits;
    if (!link.config_frame_select_n) begin
      next_shift_in = {shift_in[gyro_link_pkg::CTRL_W-2:0], link.din};
      if (cfg_bits != CFG_FULL) begin
        next_cfg_bits = cfg_bits + 4'h1;
      end
    end
  end

  always_ff @(posedge link.sclk or negedge reset_n) begin
    if (!reset_n) begin
      shift_in <= 8'h00;
    end else begin
      shift_in <= next_shift_in;
    end
  end

  // bits counted per config frame, so each frame is judged on its own
  always_ff @(posedge link.sclk or negedge cfg_clr_n) begin
    if (!cfg_clr_n) begin
      cfg_bits <= 4'h0;
    end else begin
      cfg_bits <= next_cfg_bits;
    end
  end

  // the control register loads when the config frame ends
  always_comb begin
    next_control = shift_in;
    next_short_config = cfg_bits != CFG_FULL;
  end

  always_ff @(posedge link.config_frame_select_n or negedge reset_n) begin
    if (!reset_n) begin
      control <= gyro_link_pkg::CTRL_RESET;
      short_config_frame <= 1'b0;
    end else begin
      control <= next_control;
      short_config_frame <= next_short_config;
    end
  end

  // the selected input is frozen as the conversion starts
  always_comb begin
    next_held = rate_sample;
    unique case (sel)
      gyro_link_pkg::SRC_RATE: next_held = rate_sample;
      gyro_link_pkg::SRC_TEMP: next_held = temp_sample;
      gyro_link_pkg::SRC_AUX_ONE: next_held = aux_one_sample;
      gyro_link_pkg::SRC_AUX_TWO: next_held = aux_two_sample;
    endcase
    next_held = to_offset(next_held);
  end

  always_ff @(negedge link.read_frame_select_n or negedge reset_n) begin
    if (!reset_n) begin
      held <= gyro_link_pkg::MID_SCALE;
    end else begin
      held <= next_held;
    end
  end

  // falling clock edges within a read frame drive the output
  always_comb begin
    next_edge_cnt = edge_cnt;
    next_out_shift = out_shift;
    next_dout_q = 1'b0;
    if (edge_cnt != CW'(gyro_link_pkg::FRAME_EDGES)) begin
      next_edge_cnt = edge_cnt + CW'(1);
    end
    if (next_edge_cnt == CW'(gyro_link_pkg::FIRST_OUT_EDGE)) begin
      next_dout_q = held[gyro_link_pkg::RES_W-1];
      next_out_shift = {held[gyro_link_pkg::RES_W-2:0], 1'b0};
    end else if (next_edge_cnt > CW'(gyro_link_pkg::FIRST_OUT_EDGE)
      && next_edge_cnt <= CW'(gyro_link_pkg::LAST_OUT_EDGE)) begin
      next_dout_q = out_shift[gyro_link_pkg::RES_W-1];
      next_out_shift = {out_shift[gyro_link_pkg::RES_W-2:0], 1'b0};
    end
  end

  always_ff @(negedge link.sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      edge_cnt <= '0;
      out_shift <= '0;
      dout_q <= 1'b0;
    end else begin
      edge_cnt <= next_edge_cnt;
      out_shift <= next_out_shift;
      dout_q <= next_dout_q;
    end
  end

  // length of the last read frame, caught at its end
  always_comb begin
    next_last_cnt = edge_cnt;
  end

  always_ff @(posedge link.read_frame_select_n or negedge reset_n) begin
    if (!reset_n) begin
      last_cnt <= CW'(gyro_link_pkg::FRAME_EDGES);
    end else begin
      last_cnt <= next_last_cnt;
    end
  end
endmodule

// File: src/gyro_link_pkg.sv
// constants, types and register map shared by both ends of the gyro readout link
package gyro_link_pkg;
  localparam int RES_W = 14;
  localparam int CTRL_W = 8;
  localparam int FRAME_EDGES = 20;
  localparam int FIRST_OUT_EDGE = 6;
  localparam int LAST_OUT_EDGE = FIRST_OUT_EDGE + RES_W - 1;
  localparam int CNT_W = 5;
  localparam logic [RES_W-1:0] MID_SCALE = 14'h2000;
  // control register fields
  localparam int BIT_AUX_ONE = 6;
  localparam int BIT_RATE = 5;
  localparam int BIT_TEMP = 4;
  localparam int BIT_ST_POS = 1;
  localparam int BIT_ST_NEG = 0;
  localparam logic [CTRL_W-1:0] CTRL_RATE = 8'h20;
  localparam logic [CTRL_W-1:0] CTRL_TEMP = 8'h10;
  localparam logic [CTRL_W-1:0] CTRL_AUX_TWO = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_AUX_ONE = 8'h40;
  localparam logic [CTRL_W-1:0] CTRL_ST_POS = 8'h22;
  localparam logic [CTRL_W-1:0] CTRL_ST_NEG = 8'h21;
  localparam logic [CTRL_W-1:0] CTRL_RESET = CTRL_RATE;
  // host register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_COMMAND = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] REG_RESULT = 4'hc;
  localparam int CMD_READ = 0;
  localparam int CMD_CONFIG = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_VALID = 1;
  // host timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TEMP_ACQ_NS = 40;
  localparam int TEMP_ACQ_CYCLES = (TEMP_ACQ_NS * 1000 * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS + 1;
  typedef enum logic [3:0] {
    SRC_RATE = 4'h1,
    SRC_TEMP = 4'h2,
    SRC_AUX_ONE = 4'h4,
    SRC_AUX_TWO = 4'h8
  } source_t;
endpackage

// File: src/gyro_link_if.sv
// serial link between the gyro readout port and its host
`timescale 1ns/100ps
interface gyro_link_if;
  logic sclk;
  logic read_frame_select_n;
  logic config_frame_select_n;
  logic din;
  logic dout;
  modport device (
    input sclk,
    input read_frame_select_n,
    input config_frame_select_n,
    input din,
    output dout
  );
  modport host (
    output sclk,
    output read_frame_select_n,
    output config_frame_select_n,
    output din,
    input dout
  );
endinterface

// File: src/gyro_link_host.sv
// host end: register port and serial master for the gyro readout link
`timescale 1ns/100ps
module gyro_link_host #(
  parameter int SCLK_HALF = 16,
  parameter int GAP_CYCLES = gyro_link_pkg::TEMP_ACQ_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  gyro_link_if.host link,
  input wire logic [gyro_link_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [31:0] rdata
);
  // divider and gap counters are 8 and 16 bits wide
  if (SCLK_HALF < 4 || SCLK_HALF > 255 || GAP_CYCLES < 1 || GAP_CYCLES > 65535) begin
    $error("gyro_link_host: unsupported parameter");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_GAP = 3'b100
  } state_t;

  state_t state, next_state;
  logic is_read, next_is_read;
  logic [7:0] div, next_div;
  logic [5:0] half, next_half;
  logic [15:0] gap, next_gap;
  logic [gyro_link_pkg::CTRL_W-1:0] cfg, next_cfg;
  logic [gyro_link_pkg::RES_W-1:0] result, next_result;
  logic [gyro_link_pkg::RES_W-1:0] prev, next_prev;
  logic [gyro_link_pkg::RES_W-1:0] shreg, next_shreg;
  logic valid, next_valid;
  logic din_q, next_din_q;
  logic [31:0] next_rdata;
  logic dout_meta, dout_sync;
  logic link_sclk, next_link_sclk;
  logic read_sel_n, next_read_sel_n;
  logic config_sel_n, next_config_sel_n;
  logic tick;
  logic [5:0] last_half;
  logic [4:0] k;

  assign tick = div == 8'(SCLK_HALF - 1);
  assign k = half[5:1];
  assign last_half = is_read ? 6'(2 * gyro_link_pkg::FRAME_EDGES)
    : 6'(2 * gyro_link_pkg::CTRL_W);
  // link clock and selects come straight from flops so that no decode glitch reaches them
  assign link.sclk = link_sclk;
  assign link.read_frame_select_n = read_sel_n;
  assign link.config_frame_select_n = config_sel_n;
  assign link.din = din_q;

  always_comb begin
    next_state = state;
    next_is_read = is_read;
    next_div = (state == ST_RUN && !tick) ? div + 8'h01 : 8'h00;
    next_half = half;
    next_gap = gap;
    next_cfg = cfg;
    next_result = result;
    next_prev = prev;
    next_shreg = shreg;
    next_valid = valid;
    next_din_q = din_q;
    if (write_strobe && addr == gyro_link_pkg::REG_CONFIG) begin
      next_cfg = wdata[gyro_link_pkg::CTRL_W-1:0];
    end
    unique case (state)
      ST_IDLE: begin
        next_half = '0;
        if (write_strobe && addr == gyro_link_pkg::REG_COMMAND) begin
          if (wdata[gyro_link_pkg::CMD_READ]) begin
            next_state = ST_RUN;
            next_is_read = 1'b1;
            next_valid = 1'b0;
          end else if (wdata[gyro_link_pkg::CMD_CONFIG]) begin
            next_state = ST_RUN;
            next_is_read = 1'b0;
          end
        end
      end
      ST_RUN: begin
        if (tick) begin
          next_half = half + 6'h01;
          if (!half[0] && !is_read) begin
            // falling edge: present next config bit, msb first
            next_din_q = cfg[3'(gyro_link_pkg::CTRL_W - 1 - int'(k))];
          end
          if (!half[0] && is_read && k >= 5'(gyro_link_pkg::FIRST_OUT_EDGE)
            && k <= 5'(gyro_link_pkg::LAST_OUT_EDGE)) begin
            next_shreg = {shreg[gyro_link_pkg::RES_W-2:0], dout_sync};
          end
          if (half == last_half) begin
            next_state = ST_GAP;
            next_gap = '0;
            next_din_q = 1'b0;
            if (is_read) begin
              next_prev = result;
              next_result = shreg;
              next_valid = 1'b1;
            end
          end
        end
      end
      ST_GAP: begin
        next_gap = gap + 16'h0001;
        if (gap == 16'(GAP_CYCLES - 1)) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_link_sclk = (next_state == ST_RUN) ? ~next_half[0] : 1'b1;
    next_read_sel_n = ~(next_state == ST_RUN && next_is_read);
    next_config_sel_n = ~(next_state == ST_RUN && !next_is_read);
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (read_strobe) begin
      unique case (addr)
        gyro_link_pkg::REG_CONFIG: next_rdata = {24'h00_0000, cfg};
        gyro_link_pkg::REG_STATUS: next_rdata = {30'h0000_0000, valid, state != ST_IDLE};
        gyro_link_pkg::REG_RESULT: next_rdata = {2'b00, prev, 2'b00, result};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      is_read <= 1'b0;
      div <= 8'h00;
      half <= 6'h00;
      gap <= 16'h0000;
      cfg <= gyro_link_pkg::CTRL_RESET;
      result <= gyro_link_pkg::MID_SCALE;
      prev <= gyro_link_pkg::MID_SCALE;
      shreg <= '0;
      valid <= 1'b0;
      din_q <= 1'b0;
      link_sclk <= 1'b1;
      read_sel_n <= 1'b1;
      config_sel_n <= 1'b1;
      rdata <= 32'h0000_0000;
      dout_meta <= 1'b0;
      dout_sync <= 1'b0;
    end else begin
      state <= next_state;
      is_read <= next_is_read;
      div <= next_div;
      half <= next_half;
      gap <= next_gap;
      cfg <= next_cfg;
      result <= next_result;
      prev <= next_prev;
      shreg <= next_shreg;
      valid <= next_valid;
      din_q <= next_din_q;
      link_sclk <= next_link_sclk;
      read_sel_n <= next_read_sel_n;
      config_sel_n <= next_config_sel_n;
      rdata <= next_rdata;
      dout_meta <= link.dout;
      dout_sync <= dout_meta;
    end
  end
endmodule

// File: bench/gyro_link_chk.sv
// concurrent checks on the serial link between host and readout port
`timescale 1ns/100ps
module gyro_link_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic read_frame_select_n,
  input wire logic config_frame_select_n,
  input wire logic din,
  input wire logic dout
);
  logic sclk_q;
  logic [4:0] falls;
  logic [4:0] next_falls;
  always_comb begin
    next_falls = falls;
    if (read_frame_select_n && config_frame_select_n) begin
      next_falls = 5'h00;
    end else if (sclk_q && !sclk) begin
      next_falls = falls + 5'h01;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b1;
      falls <= 5'h00;
    end else begin
      sclk_q <= sclk;
      falls <= next_falls;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence read_start;
    $fell(read_frame_select_n);
  endsequence
  sequence sclk_held;
    sclk [*8];
  endsequence
  chk_frames_apart: assert property (read_frame_select_n || config_frame_select_n)
    else $error("both frame selects low");
  chk_dout_quiet: assert property (read_frame_select_n |-> !dout)
    else $error("dout driven outside read frame");
  chk_sclk_idle: assert property (read_frame_select_n && config_frame_select_n |-> sclk)
    else $error("sclk not idle high between frames");
  chk_read_start: assert property (read_start |-> sclk_held)
    else $error("sclk moved too soon after read frame start");
  chk_read_edges: assert property ($rose(read_frame_select_n) |-> falls == 5'h14)
    else $error("read frame not twenty clocks");
  chk_config_edges: assert property ($rose(config_frame_select_n) |-> falls == 5'h08)
    else $error("config frame not eight clocks");
  chk_msb_late: assert property (!read_frame_select_n && falls < 5'h05 |-> !dout)
    else $error("dout active before sixth falling edge");
  chk_tail_quiet: assert property (!read_frame_select_n && falls == 5'h14 |-> !dout)
    else $error("dout active after last result bit");
  chk_dout_hold: assert property (!read_frame_select_n && sclk && $past(sclk) |-> $stable(dout))
    else $error("dout changed while sclk high");
  chk_din_hold: assert property (!config_frame_select_n && sclk && $past(sclk) |-> $stable(din))
    else $error("din changed while sclk high");
endmodule

// File: bench/gyro_serial_readout_port_tb.sv
// self-checking bench: host and readout port joined over the serial link
`timescale 1ns/100ps
module gyro_serial_readout_port_tb;
  logic clk;
  logic reset_n;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic write_strobe;
  logic read_strobe;
  logic [31:0] rdata;
  logic [13:0] rate_sample;
  logic [13:0] temp_sample;
  logic [13:0] aux_one_sample;
  logic [13:0] aux_two_sample;
  gyro_link_pkg::source_t source;
  logic selftest_pos;
  logic selftest_neg;
  logic acquiring;
  logic converting;
  logic [7:0] control;
  logic short_read_frame;
  logic short_config_frame;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] d;
  logic [13:0] e;
  logic [13:0] prev;
  logic [7:0] codes [6] = '{gyro_link_pkg::CTRL_TEMP, gyro_link_pkg::CTRL_AUX_TWO,
    gyro_link_pkg::CTRL_AUX_ONE, gyro_link_pkg::CTRL_ST_POS, gyro_link_pkg::CTRL_RATE,
    gyro_link_pkg::CTRL_ST_NEG};
  logic [3:0] srcs [6] = '{4'h2, 4'h8, 4'h4, 4'h1, 4'h1, 4'h1};
  logic [13:0] smp [6] = '{14'h1abc, 14'h0555, 14'h3001, 14'h0000, 14'h0000, 14'h0000};
  gyro_link_if gyro_link_if_inst ();
  gyro_link_host #(.SCLK_HALF(16), .GAP_CYCLES(20)) gyro_link_host_inst (
    .clk(clk), .reset_n(reset_n), .link(gyro_link_if_inst), .addr(addr), .wdata(wdata),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata));
  gyro_readout_port gyro_readout_port_inst (
    .link(gyro_link_if_inst), .reset_n(reset_n), .rate_sample(rate_sample),
    .temp_sample(temp_sample), .aux_one_sample(aux_one_sample),
    .aux_two_sample(aux_two_sample), .source(source), .selftest_pos(selftest_pos),
    .selftest_neg(selftest_neg), .acquiring(acquiring), .converting(converting),
    .control(control), .short_read_frame(short_read_frame),
    .short_config_frame(short_config_frame));
  gyro_link_chk gyro_link_chk_inst (
    .clk(clk), .reset_n(reset_n), .sclk(gyro_link_if_inst.sclk),
    .read_frame_select_n(gyro_link_if_inst.read_frame_select_n),
    .config_frame_select_n(gyro_link_if_inst.config_frame_select_n),
    .din(gyro_link_if_inst.din), .dout(gyro_link_if_inst.dout));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_idle();
    int n = 0;
    logic [31:0] s = 32'h0000_0001;
    while (s[0] !== 1'b0 && n < 2000) begin
      rd(gyro_link_pkg::REG_STATUS, s);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, s, 32'h0000_0000);
      stop_test();
    end
  endtask
  task automatic frame(input logic [31:0] cmd);
    wr(gyro_link_pkg::REG_COMMAND, cmd);
    wait_idle();
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, cycles, 32'h0000_0000);
      stop_test();
    end
  end
  initial begin
    reset_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    rate_sample = 14'h0000;
    temp_sample = 14'h1abc;
    aux_one_sample = 14'h3001;
    aux_two_sample = 14'h0555;
    prev = gyro_link_pkg::MID_SCALE;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(gyro_link_pkg::REG_CONFIG, d);
    chk(d, 32'h0000_0020);
    rd(4'h2, d);
    chk(d, 32'h0000_0000);
    rd(gyro_link_pkg::REG_STATUS, d);
    chk(d, 32'h0000_0000);
    chk(32'(control), 32'(gyro_link_pkg::CTRL_RESET));
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wr(gyro_link_pkg::REG_CONFIG, 32'(codes[i]));
      frame(32'h0000_0002);
      chk(32'(control), 32'(codes[i]));
      chk(32'(source), 32'(srcs[i]));
      chk(32'({selftest_pos, selftest_neg}), 32'(codes[i][1:0]));
      frame(32'h0000_0001);
      e = smp[i] ^ gyro_link_pkg::MID_SCALE;
      rd(gyro_link_pkg::REG_RESULT, d);
      chk(d, {2'b00, prev, 2'b00, e});
      prev = e;
      rd(gyro_link_pkg::REG_STATUS, d);
      chk(d, 32'h0000_0002);
      chk(32'({short_read_frame, short_config_frame}), 32'h0000_0000);
    end
    $display("test sources done");
    @(posedge clk);
    rate_sample <= 14'h0123;
    wr(gyro_link_pkg::REG_COMMAND, 32'h0000_0001);
    repeat (60) @(posedge clk);
    rate_sample <= 14'h0321;
    #1;
    chk(32'({acquiring, converting}), 32'h0000_0001);
    wr(gyro_link_pkg::REG_CONFIG, 32'(gyro_link_pkg::CTRL_TEMP));
    wr(gyro_link_pkg::REG_COMMAND, 32'h0000_0002);
    wait_idle();
    chk(32'({acquiring, converting}), 32'h0000_0002);
    chk(32'(control), 32'(gyro_link_pkg::CTRL_ST_NEG));
    frame(32'h0000_0001);
    rd(gyro_link_pkg::REG_RESULT, d);
    chk(d, {2'b00, 14'h2123, 2'b00, 14'h2321});
    $display("test hold done");
    stop_test();
  end
endmodule
